//--- iclm_core.sv
/*
  Issue control of the in-order core: per-register ready scoreboard, unit
  occupancy, memory blocking, divider sharing and forwarding latency.
  Assumes the instruction word is held stable while instr_valid is high
  and issue_ready is low, and that it comes from logic on clk.
*/
`timescale 1ns/1ns
`include "iclm_regs.svh"
module iclm_core (
  input wire logic clk,
  input wire logic srst,
  input wire logic instr_valid,
  input iclm_pkg::iclm_instr_t instr,
  output logic issue_ready,
  output logic issued,
  output logic [5:0] issued_lat,
  output logic issued_fwd,
  output logic mem_blocked,
  output logic div_done,
  output logic div_thread,
  output logic [31:0] div_quotient
);
  logic [5:0] cnt [`ICLM_NUM_REGS];
  logic [3:0] add_busy;
  logic [3:0] mul_busy;
  logic [4:0] mem_block;
  logic div_pend;
  logic [3:0] div_dest;
  logic [1:0] div_req;
  logic [1:0] div_grant;
  logic div_busy;
  logic div_done_w;
  logic div_owner;
  logic [31:0] div_q;
  logic fwd_hit;
  logic chunk_delay;
  logic is_mem;
  logic is_load;
  logic is_add;
  logic is_mul;
  logic is_div;
  logic is_fp_op;
  logic split;
  logic srcs_ok;
  logic unit_ok;
  logic base_ok;
  logic fire;
  logic [5:0] next_lat;
  logic [4:0] next_block;

  // Whole-register readiness; sub-register selects never enter this test
  function automatic logic iclm_reg_ready(input logic [3:0] idx, input logic [5:0] c,
                                          input logic pend, input logic [3:0] pdest);
    return c == 6'h00 && !(pend && pdest == idx);
  endfunction

  always_comb begin
    is_load = instr.op == iclm_pkg::ICLM_OP_LOAD || instr.op == iclm_pkg::ICLM_OP_POP;
    is_mem = is_load || instr.op == iclm_pkg::ICLM_OP_STORE;
    is_add = instr.op == iclm_pkg::ICLM_OP_FP_ADD || instr.op == iclm_pkg::ICLM_OP_FP_ADD_PD;
    is_mul = instr.op == iclm_pkg::ICLM_OP_FP_MUL || instr.op == iclm_pkg::ICLM_OP_FP_MUL_PD;
    is_div = instr.op == iclm_pkg::ICLM_OP_FP_DIV;
    is_fp_op = is_add || is_mul || is_div;
  end

  // A wide load that runs past the end of its line
  assign split = is_load && instr.size == `ICLM_WIDE_SIZE
    && ({1'b0, instr.addr[5:0]} + 7'h10) > `ICLM_LINE_BYTES;

  always_comb begin
    srcs_ok = 1'b1;
    if (instr.use_a && !iclm_reg_ready(instr.src_a, cnt[instr.src_a], div_pend, div_dest)) begin
      srcs_ok = 1'b0;
    end
    if (instr.use_b && !iclm_reg_ready(instr.src_b, cnt[instr.src_b], div_pend, div_dest)) begin
      srcs_ok = 1'b0;
    end
    if (instr.op == iclm_pkg::ICLM_OP_SHIFT_REG
        && !iclm_reg_ready(`ICLM_COUNT_REG, cnt[`ICLM_COUNT_REG], div_pend, div_dest)) begin
      srcs_ok = 1'b0;
    end
    if (instr.has_dest && !iclm_reg_ready(instr.dest, cnt[instr.dest], div_pend, div_dest)) begin
      srcs_ok = 1'b0;
    end
  end

  always_comb begin
    unit_ok = 1'b1;
    if (is_add && add_busy != 4'h0) begin
      unit_ok = 1'b0;
    end
    if (is_mul && mul_busy != 4'h0) begin
      unit_ok = 1'b0;
    end
  end

  assign base_ok = instr_valid && srcs_ok && unit_ok && mem_block == 5'h00;
  assign div_req = (base_ok && is_div) ? (instr.thread ? 2'h2 : 2'h1) : 2'h0;
  assign fire = base_ok && (!is_div || div_grant != 2'h0);
  assign issue_ready = fire;

  // Counter value loaded into the destination: cycles until a consumer may issue, minus one
  always_comb begin
    next_lat = `ICLM_LAT_INT - 6'h01;
    case (instr.op)
      iclm_pkg::ICLM_OP_SHIFT_IMM: next_lat = `ICLM_LAT_SHIFT_IMM - 6'h01;
      iclm_pkg::ICLM_OP_SHIFT_REG: next_lat = `ICLM_LAT_SHIFT_REG - 6'h01;
      iclm_pkg::ICLM_OP_LEA: next_lat = (`ICLM_LAT_INT - 6'h01)
        + (instr.narrow ? `ICLM_NARROW_PEN : 6'h00);
      iclm_pkg::ICLM_OP_LOAD,
      iclm_pkg::ICLM_OP_POP: begin
        next_lat = (fwd_hit ? `ICLM_LAT_FWD : `ICLM_LAT_LOAD) - 6'h01;
        if (instr.narrow) begin
          next_lat = next_lat + `ICLM_NARROW_PEN;
        end
        if (chunk_delay) begin
          next_lat = next_lat + `ICLM_CHUNK_PEN;
        end
        if (split) begin
          next_lat = next_lat + {1'b0, `ICLM_SPLIT_PEN};
        end else if (instr.miss) begin
          next_lat = next_lat + {1'b0, `ICLM_MISS_PEN};
        end
      end
      iclm_pkg::ICLM_OP_FP_ADD: next_lat = `ICLM_LAT_FP_ADD - 6'h01 + `ICLM_FP_WB_DELAY;
      iclm_pkg::ICLM_OP_FP_ADD_PD: next_lat = `ICLM_LAT_FP_ADD_PD - 6'h01
        + `ICLM_FP_WB_DELAY;
      iclm_pkg::ICLM_OP_FP_MUL: next_lat = `ICLM_LAT_FP_MUL - 6'h01 + `ICLM_FP_WB_DELAY;
      iclm_pkg::ICLM_OP_FP_MUL_PD: next_lat = `ICLM_LAT_FP_MUL_PD - 6'h01
        + `ICLM_FP_WB_DELAY;
      iclm_pkg::ICLM_OP_FP_DIV: next_lat = 6'h00;
      default: next_lat = `ICLM_LAT_INT - 6'h01;
    endcase
  end

  always_comb begin
    next_block = 5'h00;
    if (split) begin
      next_block = `ICLM_SPLIT_PEN - 5'h01;
    end else if (is_mem && instr.miss) begin
      next_block = `ICLM_MISS_PEN - 5'h01;
    end
  end

  generate
    for (genvar i = 0; i < `ICLM_NUM_REGS; i++) begin : g_sb
      always_ff @(posedge clk) begin
        if (srst) begin
          cnt[i] <= 6'h00;
        end else if (fire && instr.has_dest && instr.dest == 4'(i)) begin
          cnt[i] <= next_lat;
        end else if (div_done_w && div_dest == 4'(i)) begin
          cnt[i] <= `ICLM_FP_WB_DELAY;
        end else if (cnt[i] != 6'h00) begin
          cnt[i] <= cnt[i] - 6'h01;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      add_busy <= 4'h0;
    end else if (fire && instr.op == iclm_pkg::ICLM_OP_FP_ADD_PD) begin
      add_busy <= `ICLM_INT_FP_ADD_PD - 4'h1;
    end else if (add_busy != 4'h0) begin
      add_busy <= add_busy - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mul_busy <= 4'h0;
    end else if (fire && instr.op == iclm_pkg::ICLM_OP_FP_MUL_PD) begin
      mul_busy <= `ICLM_INT_FP_MUL_PD - 4'h1;
    end else if (fire && instr.op == iclm_pkg::ICLM_OP_FP_MUL) begin
      mul_busy <= `ICLM_INT_FP_MUL - 4'h1;
    end else if (mul_busy != 4'h0) begin
      mul_busy <= mul_busy - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_block <= 5'h00;
    end else if (fire && is_mem) begin
      mem_block <= next_block;
    end else if (mem_block != 5'h00) begin
      mem_block <= mem_block - 5'h01;
    end
  end

  // Destination held not-ready until the divider reports completion
  always_ff @(posedge clk) begin
    if (srst) begin
      div_pend <= 1'b0;
      div_dest <= 4'h0;
    end else if (fire && is_div) begin
      div_pend <= instr.has_dest;
      div_dest <= instr.dest;
    end else if (div_done_w) begin
      div_pend <= 1'b0;
    end
  end

  iclm_divider u_div (
    .clk(clk),
    .srst(srst),
    .req(div_req),
    .dividend(instr.dividend),
    .divisor(instr.divisor),
    .dwidth(instr.dwidth),
    .grant(div_grant),
    .busy(div_busy),
    .done(div_done_w),
    .owner(div_owner),
    .quotient(div_q)
  );

  iclm_mem_track u_mem (
    .clk(clk),
    .srst(srst),
    .acc_valid(instr_valid && is_mem),
    .acc_take(fire && is_mem),
    .is_store(instr.op == iclm_pkg::ICLM_OP_STORE),
    .is_fp(instr.fp_data),
    .addr(instr.addr),
    .size(instr.size),
    .fwd_hit(fwd_hit),
    .chunk_delay(chunk_delay)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      issued <= 1'b0;
      issued_lat <= 6'h00;
      issued_fwd <= 1'b0;
    end else begin
      issued <= fire;
      issued_lat <= fire ? next_lat : 6'h00;
      issued_fwd <= fire && is_load && fwd_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_blocked <= 1'b0;
      div_done <= 1'b0;
      div_thread <= 1'b0;
      div_quotient <= 32'h0;
    end else begin
      mem_blocked <= (fire && is_mem) ? (next_block != 5'h00) : (mem_block > 5'h01);
      div_done <= div_done_w;
      if (div_done_w) begin
        div_thread <= div_owner;
        div_quotient <= div_q;
      end
    end
  end

  a_shift_imm_lat: assert property (@(posedge clk) disable iff (srst)
    fire && instr.op == iclm_pkg::ICLM_OP_SHIFT_IMM && instr.has_dest
    |=> cnt[$past(instr.dest)] == 6'h00) else $error("immediate shift latency wrong");

  a_shift_reg_lat: assert property (@(posedge clk) disable iff (srst)
    fire && instr.op == iclm_pkg::ICLM_OP_SHIFT_REG && instr.has_dest
    |=> cnt[$past(instr.dest)] == 6'h02 ##1 cnt[$past(instr.dest, 2)] == 6'h01)
    else $error("register shift latency wrong");

  a_count_reg_wait: assert property (@(posedge clk) disable iff (srst)
    fire && instr.op == iclm_pkg::ICLM_OP_SHIFT_REG |-> cnt[`ICLM_COUNT_REG] == 6'h00)
    else $error("shift issued before count ready");

  a_source_ready: assert property (@(posedge clk) disable iff (srst)
    fire && instr.use_a |-> cnt[instr.src_a] == 6'h00 && !(div_pend && div_dest == instr.src_a))
    else $error("dependent issued early");

  a_add_pd_gap: assert property (@(posedge clk) disable iff (srst)
    fire && instr.op == iclm_pkg::ICLM_OP_FP_ADD_PD |=> !(fire && is_add) [*4])
    else $error("packed double add issued too soon");

  a_mul_pd_gap: assert property (@(posedge clk) disable iff (srst)
    fire && instr.op == iclm_pkg::ICLM_OP_FP_MUL_PD |=> !(fire && is_mul) [*8])
    else $error("packed double multiply issued too soon");

  a_fp_wb_delay: assert property (@(posedge clk) disable iff (srst)
    fire && instr.op == iclm_pkg::ICLM_OP_FP_ADD && instr.has_dest
    |=> cnt[$past(instr.dest)] == 6'h06) else $error("fp writeback delay missing");

  a_split_block: assert property (@(posedge clk) disable iff (srst)
    fire && split |=> !fire [*8] ##1 mem_block == 5'h05)
    else $error("line split penalty wrong");

  a_fwd_int_only: assert property (@(posedge clk) disable iff (srst)
    fwd_hit |-> !instr.fp_data && instr.size <= `ICLM_FWD_MAX_SIZE)
    else $error("forwarding outside integer pipe");

  a_div_release: assert property (@(posedge clk) disable iff (srst)
    div_done_w && div_pend && !(fire && is_div)
    |=> !div_pend && cnt[$past(div_dest)] == `ICLM_FP_WB_DELAY)
    else $error("divide result release wrong");

  a_lea_narrow: assert property (@(posedge clk) disable iff (srst)
    fire && instr.op == iclm_pkg::ICLM_OP_LEA && instr.has_dest && instr.narrow
    |=> cnt[$past(instr.dest)] == `ICLM_NARROW_PEN) else $error("narrow penalty missing");

  a_split_lat: assert property (@(posedge clk) disable iff (srst)
    fire && split && instr.has_dest
    |=> cnt[$past(instr.dest)] > {1'b0, `ICLM_SPLIT_PEN}) else $error("split latency short");

  a_miss_block: assert property (@(posedge clk) disable iff (srst)
    fire && is_mem && instr.miss && !split
    |=> mem_block == `ICLM_MISS_PEN - 5'h01) else $error("miss block length wrong");

  a_block_stall: assert property (@(posedge clk) disable iff (srst)
    mem_block != 5'h00 |-> !fire)
    else $error("issue during memory block");

  a_fwd_flag: assert property (@(posedge clk) disable iff (srst)
    fire && is_load && fwd_hit
    |=> issued_fwd) else $error("forwarded load not flagged");

  a_chunk_pen: assert property (@(posedge clk) disable iff (srst)
    fire && is_load && chunk_delay
    |=> issued_lat >= `ICLM_LAT_FWD - 6'h01 + `ICLM_CHUNK_PEN) else $error("chunk delay lost");

  a_add_pd_lat: assert property (@(posedge clk) disable iff (srst)
    fire && instr.op == iclm_pkg::ICLM_OP_FP_ADD_PD && instr.has_dest
    |=> cnt[$past(instr.dest)] == `ICLM_LAT_FP_ADD_PD - 6'h01 + `ICLM_FP_WB_DELAY)
    else $error("packed double add latency wrong");

  a_mul_pd_lat: assert property (@(posedge clk) disable iff (srst)
    fire && instr.op == iclm_pkg::ICLM_OP_FP_MUL_PD && instr.has_dest
    |=> cnt[$past(instr.dest)] == `ICLM_LAT_FP_MUL_PD - 6'h01 + `ICLM_FP_WB_DELAY)
    else $error("packed double multiply latency wrong");

  a_div_refuse: assert property (@(posedge clk) disable iff (srst)
    div_busy |-> !(fire && is_div))
    else $error("divide taken while busy");

  a_div_owner: assert property (@(posedge clk) disable iff (srst)
    div_done_w |=> div_done && div_thread == $past(div_owner))
    else $error("divide result owner wrong");
endmodule // iclm_core

//--- iclm_divider.sv
/*
  Shared radix-2 restoring divider with round-robin arbitration between threads.
  Assumes the requester holds dividend and width stable in the cycle a grant is given, and the divisor while busy.
*/
`timescale 1ns/1ns
`include "iclm_regs.svh"
module iclm_divider (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] req,
  input wire logic [31:0] dividend,
  input wire logic [31:0] divisor,
  input wire logic [1:0] dwidth,
  output logic [1:0] grant,
  output logic busy,
  output logic done,
  output logic owner,
  output logic [31:0] quotient
);
  logic prio;
  logic [5:0] cnt;
  logic [31:0] rem;
  logic [31:0] quo;
  logic [32:0] sh;
  logic [32:0] diff;
  logic [5:0] nbits;

  // Width, trimmed by leading zero bytes so small values finish early
  function automatic logic [5:0] iclm_div_bits(input logic [31:0] v, input logic [1:0] w);
    logic [5:0] n;
    n = (w == 2'h0) ? 6'h08 : (w == 2'h1) ? 6'h10 : 6'h20;
    for (int k = 0; k < 3; k++) begin
      if (n > 6'h08 && (v >> (n - 6'h08)) == 32'h0) begin
        n = n - 6'h08;
      end
    end
    return n;
  endfunction

  always_comb begin
    grant = 2'h0;
    if (!busy) begin
      if (req == 2'h3) begin
        grant = prio ? 2'h2 : 2'h1;
      end else begin
        grant = req;
      end
    end
  end

  assign nbits = iclm_div_bits(dividend, dwidth);
  assign sh = {rem, quo[31]};
  assign diff = sh - {1'b0, divisor};

  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
      cnt <= 6'h00;
      rem <= 32'h0;
      quo <= 32'h0;
      owner <= 1'b0;
      prio <= 1'b0;
    end else if (|grant) begin
      busy <= 1'b1;
      cnt <= nbits;
      rem <= 32'h0;
      quo <= dividend << (6'h20 - nbits);
      owner <= grant[1];
      prio <= ~grant[1];
    end else if (busy) begin
      rem <= diff[32] ? sh[31:0] : diff[31:0];
      quo <= {quo[30:0], ~diff[32]};
      cnt <= cnt - 6'h01;
      busy <= (cnt != 6'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      done <= 1'b0;
      quotient <= 32'h0;
    end else begin
      done <= busy && cnt == 6'h01;
      if (busy && cnt == 6'h01) begin
        quotient <= {quo[30:0], ~diff[32]};
      end
    end
  end

  a_div_grant_one: assert property (@(posedge clk) disable iff (srst)
    (busy |-> grant == 2'h0) and $onehot0(grant)) else $error("divider granted twice");
endmodule // iclm_divider

//--- iclm_mem_track.sv
/*
  Store forwarding match and cache chunk conflict tracking for memory accesses.
  Assumes acc_take pulses only in the cycle the described access issues.
*/
`timescale 1ns/1ns
`include "iclm_regs.svh"
module iclm_mem_track (
  input wire logic clk,
  input wire logic srst,
  input wire logic acc_valid,
  input wire logic acc_take,
  input wire logic is_store,
  input wire logic is_fp,
  input wire logic [11:0] addr,
  input wire logic [2:0] size,
  output logic fwd_hit,
  output logic chunk_delay
);
  logic st_valid;
  logic [11:0] st_addr;
  logic [2:0] st_size;
  logic last_sub;
  logic [9:0] last_chunk;
  logic [3:0] last_mask;
  logic [3:0] mask;

  assign mask = (size == 3'h0) ? (4'h1 << addr[1:0]) : (4'h3 << addr[1:0]);
  assign fwd_hit = acc_valid && !is_store && !is_fp && st_valid
    && st_addr == addr && st_size == size && size <= `ICLM_FWD_MAX_SIZE;
  assign chunk_delay = acc_valid && size < 3'h2 && last_sub
    && last_chunk == addr[11:2] && last_mask != mask;

  always_ff @(posedge clk) begin
    if (srst) begin
      st_valid <= 1'b0;
      st_addr <= 12'h000;
      st_size <= 3'h0;
    end else if (acc_take && is_store) begin
      st_valid <= !is_fp;
      st_addr <= addr;
      st_size <= size;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      last_sub <= 1'b0;
      last_chunk <= 10'h000;
      last_mask <= 4'h0;
    end else if (acc_take) begin
      last_sub <= size < 3'h2;
      last_chunk <= addr[11:2];
      last_mask <= mask;
    end
  end
endmodule // iclm_mem_track

//--- iclm_pkg.sv
/*
  Types of the in-order core issue latency model.
  Assumes iclm_regs.svh is on the include path.
*/
package iclm_pkg;
  typedef enum logic [3:0] {
    ICLM_OP_NOP = 4'h0,
    ICLM_OP_INT = 4'h1,
    ICLM_OP_SHIFT_IMM = 4'h2,
    ICLM_OP_SHIFT_REG = 4'h3,
    ICLM_OP_LEA = 4'h4,
    ICLM_OP_LOAD = 4'h5,
    ICLM_OP_POP = 4'h6,
    ICLM_OP_STORE = 4'h7,
    ICLM_OP_FP_ADD = 4'h8,
    ICLM_OP_FP_ADD_PD = 4'h9,
    ICLM_OP_FP_MUL = 4'hA,
    ICLM_OP_FP_MUL_PD = 4'hB,
    ICLM_OP_FP_DIV = 4'hC
  } iclm_op_t;

  typedef struct packed {
    logic thread;
    iclm_op_t op;
    logic has_dest;
    logic [3:0] dest;
    logic use_a;
    logic [3:0] src_a;
    logic use_b;
    logic [3:0] src_b;
    logic [1:0] subreg;
    logic narrow;
    logic fp_data;
    logic miss;
    logic [2:0] size;
    logic [11:0] addr;
    logic [1:0] dwidth;
    logic [31:0] dividend;
    logic [31:0] divisor;
  } iclm_instr_t;
endpackage

//--- iclm_regs.svh
/*
  Constants for the in-order core issue latency model: unit latencies,
  issue intervals, penalties and register indices.
  Assumes inclusion by the design modules only.
*/
// Overview of operation
// - A shift with an immediate count has a one-cycle result latency.
// - A shift by the count register waits for that register; latency three.
// - Dependencies track whole registers; byte halves are not independent, no merge cost.
// - Address compute, loads and pops run slower on inputs under four bytes.
// - FP adds take 5 cycles, one per cycle; packed-double add 6, every 5.
// - Packed-double multiply is unpipelined: 9 cycles latency, one per 9 cycles.
// - Divide uses an iterative radix-2 unit, value dependent.
// - One divider serves both threads, arbitrated between them.
// - Consumers of floating-point results wait two extra cycles for late writeback.
// - A 16-byte load crossing a cache line costs 14 cycles.
// - Memory hazards make an access expensive and block younger issue; the code blocks only for line splits and misses, not chunk conflicts.
// - Store forwarding happens in the integer pipe only, never for FP/SIMD data.
// - Forwarding needs equal size and address, and at most eight bytes.
// - The forwarding match compares only the low twelve address bits.
// - Each 64-byte data cache line is handled as sixteen 4-byte chunks.
// - Sub-word accesses touching different bytes of one chunk may be delayed.
`ifndef ICLM_REGS_SVH
`define ICLM_REGS_SVH
`define ICLM_NUM_REGS 16
`define ICLM_COUNT_REG 4'h1
`define ICLM_LAT_INT 6'h01
`define ICLM_LAT_SHIFT_IMM 6'h01
`define ICLM_LAT_SHIFT_REG 6'h03
`define ICLM_LAT_LOAD 6'h03
`define ICLM_LAT_FWD 6'h02
`define ICLM_LAT_FP_ADD 6'h05
`define ICLM_LAT_FP_ADD_PD 6'h06
`define ICLM_LAT_FP_MUL 6'h05
`define ICLM_LAT_FP_MUL_PD 6'h09
`define ICLM_INT_FP_ADD_PD 4'h5
`define ICLM_INT_FP_MUL 4'h2
`define ICLM_INT_FP_MUL_PD 4'h9
`define ICLM_FP_WB_DELAY 6'h02
`define ICLM_NARROW_PEN 6'h01
`define ICLM_CHUNK_PEN 6'h01
`define ICLM_SPLIT_PEN 5'h0E
`define ICLM_MISS_PEN 5'h08
`define ICLM_LINE_BYTES 7'h40
`define ICLM_WIDE_SIZE 3'h4
`define ICLM_FWD_MAX_SIZE 3'h3
`endif

//--- tb_inorder_core_latency_model.sv
/*
  Self-checking bench for the in-order core issue model: result latencies,
  unit intervals, memory penalties, store forwarding and the shared divider.
  Assumes iclm_pkg is compiled first and the core runs on one 50 MHz clock.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t ns: got %0h expected %0h", $time, g, e); end end
module tb_inorder_core_latency_model;
  logic clk;
  logic srst;
  logic instr_valid;
  iclm_pkg::iclm_instr_t instr;
  logic issue_ready;
  logic issued;
  logic [5:0] issued_lat;
  logic issued_fwd;
  logic mem_blocked;
  logic div_done;
  logic div_thread;
  logic [31:0] div_quotient;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int take_cyc = 0;
  logic dq_thr[$];
  logic [31:0] dq_quo[$];
  int dq_cyc[$];

  iclm_core dut_u (.clk(clk), .srst(srst), .instr_valid(instr_valid), .instr(instr),
    .issue_ready(issue_ready), .issued(issued), .issued_lat(issued_lat),
    .issued_fwd(issued_fwd), .mem_blocked(mem_blocked), .div_done(div_done),
    .div_thread(div_thread), .div_quotient(div_quotient));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Divider results are logged on the edge after they appear
  always @(posedge clk) begin
    cyc++;
    if (div_done === 1'b1) begin
      dq_thr.push_back(div_thread);
      dq_quo.push_back(div_quotient);
      dq_cyc.push_back(cyc);
    end
  end

  function automatic iclm_pkg::iclm_instr_t mk(input iclm_pkg::iclm_op_t op,
    input logic [4:0] d, input logic [4:0] s, input logic [2:0] size = 3'h2,
    input logic [11:0] addr = 12'h000);
    mk = '0;
    mk.op = op;
    mk.has_dest = d[4];
    mk.dest = d[3:0];
    mk.use_a = s[4];
    mk.src_a = s[3:0];
    mk.size = size;
    mk.addr = addr;
  endfunction

  task automatic end_sim;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Presents one instruction from a falling edge and counts stalled cycles
  task automatic issue(input iclm_pkg::iclm_instr_t ins, output int w,
    output logic [5:0] l, output logic f);
    w = 0;
    instr <= ins;
    instr_valid <= 1'b1;
    #1;
    while (issue_ready !== 1'b1 && w < 300) begin
      @(negedge clk);
      w++;
      #1;
    end
    `CHK(issue_ready, 1'b1)
    @(posedge clk);
    @(negedge clk);
    take_cyc = cyc;
    `CHK(issued, 1'b1)
    l = issued_lat;
    f = issued_fwd;
  endtask

  task automatic idle(input int n);
    instr_valid <= 1'b0;
    repeat (n) @(negedge clk);
  endtask

  // Producer then consumer back to back; 6'h3F skips the producer latency
  task automatic pair(input iclm_pkg::iclm_instr_t p, input iclm_pkg::iclm_instr_t c,
    input logic [5:0] lat_p, input int wait_c, input logic [5:0] lat_c, input logic fwd_c);
    int w;
    logic [5:0] l;
    logic f;
    issue(p, w, l, f);
    if (lat_p !== 6'h3F) `CHK(l, lat_p)
    issue(c, w, l, f);
    `CHK(w, wait_c)
    `CHK(l, lat_c)
    `CHK(f, fwd_c)
    idle(20);
  endtask

  task automatic t_reset;
    srst <= 1'b1;
    repeat (20) @(negedge clk);
    `CHK(issued, 1'b0)
    `CHK(div_done, 1'b0)
    `CHK(mem_blocked, 1'b0)
    `CHK(issue_ready, 1'b0)
    srst <= 1'b0;
    @(negedge clk);
  endtask

  task automatic t_shift;
    pair(mk(iclm_pkg::ICLM_OP_SHIFT_IMM, 5'h12, 5'h00), mk(iclm_pkg::ICLM_OP_INT, 5'h15, 5'h12),
      6'h00, 6'h00, 6'h00, 1'b0);
    pair(mk(iclm_pkg::ICLM_OP_SHIFT_REG, 5'h13, 5'h00), mk(iclm_pkg::ICLM_OP_INT, 5'h16, 5'h13),
      6'h02, 6'h02, 6'h00, 1'b0);
    pair(mk(iclm_pkg::ICLM_OP_FP_ADD, 5'h11, 5'h00), mk(iclm_pkg::ICLM_OP_SHIFT_REG, 5'h17, 5'h00),
      6'h06, 6'h06, 6'h02, 1'b0);
  endtask

  task automatic t_partial;
    iclm_pkg::iclm_instr_t p;
    iclm_pkg::iclm_instr_t c;
    p = mk(iclm_pkg::ICLM_OP_SHIFT_REG, 5'h14, 5'h00);
    c = mk(iclm_pkg::ICLM_OP_INT, 5'h18, 5'h14);
    c.subreg = 2'h1;
    pair(p, c, 6'h02, 6'h02, 6'h00, 1'b0);
  endtask

  task automatic t_narrow;
    iclm_pkg::iclm_op_t ops[4];
    logic [5:0] lat[4];
    iclm_pkg::iclm_instr_t p;
    ops = '{iclm_pkg::ICLM_OP_LEA, iclm_pkg::ICLM_OP_LEA, iclm_pkg::ICLM_OP_LOAD,
      iclm_pkg::ICLM_OP_POP};
    lat = '{6'h00, 6'h01, 6'h03, 6'h03};
    for (int i = 0; i < 4; i++) begin
      p = mk(ops[i], 5'h19, 5'h00, 3'h2, 12'h400 + 12'(i) * 12'h040);
      p.narrow = (i != 0);
      pair(p, mk(iclm_pkg::ICLM_OP_INT, 5'h1A, 5'h19), lat[i], lat[i], 6'h00, 1'b0);
    end
  endtask

  task automatic t_fp;
    pair(mk(iclm_pkg::ICLM_OP_FP_ADD, 5'h1A, 5'h00), mk(iclm_pkg::ICLM_OP_FP_ADD, 5'h1B, 5'h00),
      6'h06, 6'h00, 6'h06, 1'b0);
    pair(mk(iclm_pkg::ICLM_OP_FP_ADD_PD, 5'h1A, 5'h00),
      mk(iclm_pkg::ICLM_OP_FP_ADD_PD, 5'h1B, 5'h00), 6'h07, 6'h04, 6'h07, 1'b0);
    pair(mk(iclm_pkg::ICLM_OP_FP_MUL_PD, 5'h1C, 5'h00),
      mk(iclm_pkg::ICLM_OP_FP_MUL_PD, 5'h1D, 5'h00), 6'h0A, 6'h08, 6'h0A, 1'b0);
    pair(mk(iclm_pkg::ICLM_OP_FP_MUL, 5'h1C, 5'h00),
      mk(iclm_pkg::ICLM_OP_FP_MUL, 5'h1D, 5'h00), 6'h06, 6'h01, 6'h06, 1'b0);
    pair(mk(iclm_pkg::ICLM_OP_FP_ADD, 5'h1E, 5'h00), mk(iclm_pkg::ICLM_OP_INT, 5'h12, 5'h1E),
      6'h06, 6'h06, 6'h00, 1'b0);
  endtask

  task automatic t_mem;
    iclm_pkg::iclm_instr_t p;
    iclm_pkg::iclm_instr_t c;
    int w;
    logic [5:0] l;
    logic f;
    c = mk(iclm_pkg::ICLM_OP_INT, 5'h16, 5'h00);
    pair(mk(iclm_pkg::ICLM_OP_LOAD, 5'h15, 5'h00, 3'h4, 12'hFF8), c,
      6'h10, 6'h0D, 6'h00, 1'b0);
    pair(mk(iclm_pkg::ICLM_OP_LOAD, 5'h15, 5'h00, 3'h4, 12'h040), c,
      6'h02, 6'h00, 6'h00, 1'b0);
    p = mk(iclm_pkg::ICLM_OP_LOAD, 5'h15, 5'h00, 3'h2, 12'h300);
    p.miss = 1'b1;
    pair(p, c, 6'h0A, 6'h07, 6'h00, 1'b0);
    issue(p, w, l, f);
    `CHK(l, 6'h0A)
    `CHK(mem_blocked, 1'b1)
    idle(10);
    `CHK(mem_blocked, 1'b0)
  endtask

  task automatic t_fwd;
    iclm_pkg::iclm_instr_t s;
    iclm_pkg::iclm_instr_t l;
    s = mk(iclm_pkg::ICLM_OP_STORE, 5'h00, 5'h00, 3'h3, 12'h100);
    l = mk(iclm_pkg::ICLM_OP_LOAD, 5'h17, 5'h00, 3'h3, 12'h100);
    pair(s, l, 6'h3F, 6'h00, 6'h01, 1'b1);
    l.addr = 12'h108;
    pair(s, l, 6'h3F, 6'h00, 6'h02, 1'b0);
    l.addr = 12'h100;
    l.size = 3'h2;
    pair(s, l, 6'h3F, 6'h00, 6'h02, 1'b0);
    s.size = 3'h4;
    l.size = 3'h4;
    pair(s, l, 6'h3F, 6'h00, 6'h02, 1'b0);
    s.size = 3'h3;
    l.size = 3'h3;
    l.fp_data = 1'b1;
    pair(s, l, 6'h3F, 6'h00, 6'h02, 1'b0);
    s.fp_data = 1'b1;
    l.fp_data = 1'b0;
    pair(s, l, 6'h3F, 6'h00, 6'h02, 1'b0);
  endtask

  task automatic t_chunk;
    pair(mk(iclm_pkg::ICLM_OP_LOAD, 5'h15, 5'h00, 3'h0, 12'h500),
      mk(iclm_pkg::ICLM_OP_LOAD, 5'h16, 5'h00, 3'h0, 12'h501),
      6'h02, 6'h00, 6'h03, 1'b0);
    pair(mk(iclm_pkg::ICLM_OP_LOAD, 5'h15, 5'h00, 3'h0, 12'h505),
      mk(iclm_pkg::ICLM_OP_LOAD, 5'h16, 5'h00, 3'h2, 12'h504),
      6'h02, 6'h00, 6'h02, 1'b0);
  endtask

  task automatic div_get(input logic thr, input logic [31:0] q, input int at);
    int n;
    logic t;
    logic [31:0] v;
    int c;
    n = 0;
    while (dq_thr.size() == 0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    `CHK(dq_thr.size() > 0, 1'b1)
    if (dq_thr.size() > 0) begin
      t = dq_thr.pop_front();
      v = dq_quo.pop_front();
      c = dq_cyc.pop_front();
      `CHK(t, thr)
      `CHK(v, q)
      if (at > 0) `CHK(c, at)
    end
  endtask

  // Done shows bits+1 cycles after the take and is logged one edge later
  task automatic t_div;
    iclm_pkg::iclm_instr_t d;
    int w;
    int t0;
    logic [5:0] l;
    logic f;
    d = mk(iclm_pkg::ICLM_OP_FP_DIV, 5'h19, 5'h00);
    d.dividend = 32'h0000_0064;
    d.divisor = 32'h0000_0007;
    issue(d, w, l, f);
    idle(1);
    div_get(1'b0, 32'h0000_000E, take_cyc + 10);
    d.dest = 4'hA;
    d.dividend = 32'h0000_0005;
    d.divisor = 32'h0000_0000;
    issue(d, w, l, f);
    idle(1);
    div_get(1'b0, 32'h0000_00FF, 0);
    d.dest = 4'hB;
    d.dividend = 32'h0000_00FF;
    d.divisor = 32'h0000_0010;
    issue(d, w, l, f);
    t0 = take_cyc;
    d.thread = 1'b1;
    d.dest = 4'hC;
    d.dwidth = 2'h2;
    d.dividend = 32'hFFFF_FFFF;
    issue(d, w, l, f);
    `CHK(w >= 7, 1'b1)
    idle(1);
    div_get(1'b0, 32'h0000_000F, t0 + 10);
    div_get(1'b1, 32'h0FFF_FFFF, take_cyc + 34);
    idle(20);
  endtask

  initial begin
    srst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    t_reset();
    t_shift();
    t_partial();
    t_narrow();
    t_fp();
    t_mem();
    t_fwd();
    t_chunk();
    t_div();
    end_sim();
  end

  initial begin
    #100000;
    n_errors++;
    $display("unexpected at %0t ns: run did not finish", $time);
    end_sim();
  end
endmodule // tb_inorder_core_latency_model
